// >>> verilog/lpb_led_timing_defs.vh
`ifndef LPB_LED_TIMING_DEFS_VH
`define LPB_LED_TIMING_DEFS_VH

// register indices, byte address is four times the index
`define LPB_IDX_P1_PERIOD 10'h084
`define LPB_IDX_P2_PERIOD 10'h085
`define LPB_IDX_BR_PERIOD 10'h086
`define LPB_IDX_CONFIG 10'h088
`define LPB_IDX_CONTROL 10'h08A
`define LPB_IDX_STATUS 10'h08B

`define LPB_RST_P1_PERIOD 8'h20
`define LPB_RST_P2_PERIOD 8'h14
`define LPB_RST_BR_PERIOD 8'h5D
`define LPB_RST_CONFIG 8'h04
`define LPB_RST_CONTROL 8'h00

// field positions
`define LPB_PER_MSB 6
`define LPB_START_TRIG_BIT 7
`define LPB_RAMP_ALERT_BIT 6
`define LPB_CNT2_MSB 5
`define LPB_CNT2_LSB 3
`define LPB_CNT1_MSB 2
`define LPB_CNT1_LSB 0
`define LPB_SEL_MSB 1
`define LPB_SEL_LSB 0
`define LPB_DRIVE_BIT 2
`define LPB_LINK_BIT 3
`define LPB_ALERT_FLAG_BIT 0

// behavior select codes
`define LPB_BEH_DIRECT 2'h0
`define LPB_BEH_PULSE1 2'h1
`define LPB_BEH_PULSE2 2'h2
`define LPB_BEH_BREATHE 2'h3

// timing
`define LPB_TICK_MS 32
`define LPB_CLK_KHZ 100000

// axi responses
`define LPB_RESP_OKAY 2'h0
`define LPB_RESP_SLVERR 2'h2

`endif

// >>> verilog/lpb_led_timing.v
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "lpb_led_timing_defs.vh"

// Contract
// - pulse-1 period is field times 32 ms
// - setting zero acts as one, max 4064 ms
// - bit 7 picks touch or release start
// - pulse-2 period field, reset gives 640 ms
// - breathe period field, reset gives 2976 ms
// - short periods run at reachable shortest period
// - ramp-alert bit drives alert on completion
// - touch-started behaviors never raise alert
// - pulse-2 count code plus one, reset one
// - pulse-1 count code plus one, reset five
// - each pulse ramps up then down
// - pulse-2 pulses, then counted pulses after stop
// - breathe ramps each take half period
module lpb_led_timing
#(
   parameter ADDR_W = 12,
   parameter TICK_CYCLES = `LPB_TICK_MS * `LPB_CLK_KHZ
)
(
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire touch_in,
   output wire led_out,
   output wire alert_n
);

   localparam TICK_W = $clog2(TICK_CYCLES + 1);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RUN = 2'h1;
   localparam [1:0] ST_COUNT = 2'h2;

   // bus side registers
   reg awready_ff;
   reg wready_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg arready_ff;
   reg rvalid_ff;
   reg [1:0] rresp_ff;
   reg [31:0] rdata_ff;
   reg aw_full_ff;
   reg w_full_ff;
   reg [ADDR_W-1:0] awaddr_ff;
   reg [7:0] wdata_ff;
   reg wlane0_ff;

   // software registers
   reg [7:0] p1_period_ff;
   reg [7:0] p2_period_ff;
   reg [7:0] br_period_ff;
   reg [7:0] config_ff;
   reg [7:0] control_ff;
   reg alert_flag_ff;
   reg alert_n_ff;

   // engine
   reg touch_meta_ff;
   reg touch_sync_ff;
   reg act_prev_ff;
   reg [TICK_W-1:0] div_cnt_ff;
   reg tick_ff;
   reg [1:0] state_ff;
   reg [6:0] per_ff;
   reg [6:0] pos_ff;
   reg [6:0] pwm_cnt_ff;
   reg [2:0] cnt_ff;
   reg host_run_ff;
   reg done_ff;
   reg led_out_ff;

   wire [1:0] led_behavior_select = control_ff[`LPB_SEL_MSB:`LPB_SEL_LSB];
   wire drive_bit = control_ff[`LPB_DRIVE_BIT];
   wire linked = control_ff[`LPB_LINK_BIT];
   wire pulse_start_on_release = p1_period_ff[`LPB_START_TRIG_BIT];
   wire [6:0] first_pulse_period_field = p1_period_ff[`LPB_PER_MSB:0];
   wire [6:0] second_pulse_period_field = p2_period_ff[`LPB_PER_MSB:0];
   wire [6:0] breath_period_field = br_period_ff[`LPB_PER_MSB:0];
   wire [2:0] first_pulse_repeat_count = config_ff[`LPB_CNT1_MSB:`LPB_CNT1_LSB];
   wire [2:0] second_pulse_repeat_count = config_ff[`LPB_CNT2_MSB:`LPB_CNT2_LSB];
   wire ramp_alert = config_ff[`LPB_RAMP_ALERT_BIT];

   // effective periods in ticks, zero reads as one
   wire [6:0] eff_p1 = (first_pulse_period_field == 7'h00) ? 7'h01 : first_pulse_period_field;
   wire [6:0] eff_p2 = (second_pulse_period_field == 7'h00) ? 7'h01 : second_pulse_period_field;
   wire [6:0] eff_br = (breath_period_field == 7'h00) ? 7'h01 : breath_period_field;

   wire act = linked ? touch_sync_ff : drive_bit;
   wire act_rise = act & ~act_prev_ff;
   wire act_fall = ~act & act_prev_ff;
   wire period_end = tick_ff && (pos_ff == per_ff - 7'h01);

   // triangle: up over first half, down over second half
   wire [7:0] dbl_pos = {pos_ff, 1'b0};
   wire [7:0] dbl_rem = {per_ff - pos_ff, 1'b0};
   wire [7:0] level = (dbl_pos <= {1'b0, per_ff}) ? dbl_pos : dbl_rem;

   wire [ADDR_W-3:0] wr_idx = awaddr_ff[ADDR_W-1:2];
   wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
   reg rd_hit;
   reg [7:0] rd_val;

   always @*
   begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      if (rd_idx == `LPB_IDX_P1_PERIOD)
         rd_val = p1_period_ff;
      else if (rd_idx == `LPB_IDX_P2_PERIOD)
         rd_val = p2_period_ff;
      else if (rd_idx == `LPB_IDX_BR_PERIOD)
         rd_val = br_period_ff;
      else if (rd_idx == `LPB_IDX_CONFIG)
         rd_val = config_ff;
      else if (rd_idx == `LPB_IDX_CONTROL)
         rd_val = control_ff;
      else if (rd_idx == `LPB_IDX_STATUS)
         rd_val = {3'h0, done_ff, host_run_ff, state_ff, alert_flag_ff};
      else
         rd_hit = 1'b0;
   end

   wire wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
   wire wr_ok = (wr_idx == `LPB_IDX_P1_PERIOD) || (wr_idx == `LPB_IDX_P2_PERIOD) ||
                (wr_idx == `LPB_IDX_BR_PERIOD) || (wr_idx == `LPB_IDX_CONFIG) ||
                (wr_idx == `LPB_IDX_CONTROL) || (wr_idx == `LPB_IDX_STATUS);
   wire wr_en = wr_go && wlane0_ff;
   wire alert_clr = wr_en && (wr_idx == `LPB_IDX_STATUS) && wdata_ff[`LPB_ALERT_FLAG_BIT];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `LPB_RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rresp_ff <= `LPB_RESP_OKAY;
         rdata_ff <= 32'h00000000;
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         awaddr_ff <= {ADDR_W{1'b0}};
         wdata_ff <= 8'h00;
         wlane0_ff <= 1'b0;
         p1_period_ff <= `LPB_RST_P1_PERIOD;
         p2_period_ff <= `LPB_RST_P2_PERIOD;
         br_period_ff <= `LPB_RST_BR_PERIOD;
         config_ff <= `LPB_RST_CONFIG;
         control_ff <= `LPB_RST_CONTROL;
         alert_flag_ff <= 1'b0;
         alert_n_ff <= 1'b1;
      end
      else
      begin
         // ready rises one cycle after reset, then after each response
         if (!aw_full_ff && !bvalid_ff && !awready_ff)
            awready_ff <= 1'b1;
         if (!w_full_ff && !bvalid_ff && !wready_ff)
            wready_ff <= 1'b1;
         if (s_axi_awvalid && awready_ff)
         begin
            awaddr_ff <= s_axi_awaddr;
            aw_full_ff <= 1'b1;
            awready_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff)
         begin
            wdata_ff <= s_axi_wdata[7:0];
            wlane0_ff <= s_axi_wstrb[0];
            w_full_ff <= 1'b1;
            wready_ff <= 1'b0;
         end
         if (wr_go)
         begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `LPB_RESP_OKAY : `LPB_RESP_SLVERR;
            if (wr_en)
            begin
               if (wr_idx == `LPB_IDX_P1_PERIOD)
                  p1_period_ff <= wdata_ff;
               else if (wr_idx == `LPB_IDX_P2_PERIOD)
                  p2_period_ff <= {1'b0, wdata_ff[`LPB_PER_MSB:0]};
               else if (wr_idx == `LPB_IDX_BR_PERIOD)
                  br_period_ff <= {1'b0, wdata_ff[`LPB_PER_MSB:0]};
               else if (wr_idx == `LPB_IDX_CONFIG)
                  config_ff <= {1'b0, wdata_ff[`LPB_RAMP_ALERT_BIT:0]};
               else if (wr_idx == `LPB_IDX_CONTROL)
                  control_ff <= {4'h0, wdata_ff[`LPB_LINK_BIT:0]};
            end
         end
         if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
         // completion set wins over a same-cycle clear
         alert_flag_ff <= (alert_flag_ff && !alert_clr) || done_ff;
         alert_n_ff <= !((alert_flag_ff && !alert_clr) || done_ff);
         if (!rvalid_ff && !arready_ff)
            arready_ff <= 1'b1;
         if (s_axi_arvalid && arready_ff)
         begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_val};
            rresp_ff <= rd_hit ? `LPB_RESP_OKAY : `LPB_RESP_SLVERR;
         end
         if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
      end
   end

   // 32 ms timebase
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_cnt_ff <= {TICK_W{1'b0}};
         tick_ff <= 1'b0;
      end
      else if (div_cnt_ff == TICK_CYCLES[TICK_W-1:0] - 1'b1)
      begin
         div_cnt_ff <= {TICK_W{1'b0}};
         tick_ff <= 1'b1;
      end
      else
      begin
         div_cnt_ff <= div_cnt_ff + 1'b1;
         tick_ff <= 1'b0;
      end
   end

   // behavior engine; period and pulse-1 count are captured at start, pulse-2 count at stop; select and ramp alert are read live
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         touch_meta_ff <= 1'b0;
         touch_sync_ff <= 1'b0;
         act_prev_ff <= 1'b0;
         state_ff <= ST_IDLE;
         per_ff <= 7'h01;
         pos_ff <= 7'h00;
         pwm_cnt_ff <= 7'h00;
         cnt_ff <= 3'h0;
         host_run_ff <= 1'b0;
         done_ff <= 1'b0;
         led_out_ff <= 1'b0;
      end
      else
      begin
         touch_meta_ff <= touch_in;
         touch_sync_ff <= touch_meta_ff;
         act_prev_ff <= act;
         done_ff <= 1'b0;
         // pwm frame follows the period so the ramp needs no divider;
         // short periods give coarse steps but never stall
         if (pwm_cnt_ff >= per_ff - 7'h01)
            pwm_cnt_ff <= 7'h00;
         else
            pwm_cnt_ff <= pwm_cnt_ff + 7'h01;
         if (state_ff != ST_IDLE && tick_ff)
            pos_ff <= period_end ? 7'h00 : pos_ff + 7'h01;
         case (state_ff)
            ST_IDLE:
            begin
               pos_ff <= 7'h00;
               host_run_ff <= !linked;
               if (led_behavior_select == `LPB_BEH_PULSE1)
               begin
                  if (pulse_start_on_release ? act_fall : act_rise)
                  begin
                     per_ff <= eff_p1;
                     cnt_ff <= first_pulse_repeat_count;
                     state_ff <= ST_COUNT;
                  end
               end
               else if (led_behavior_select == `LPB_BEH_PULSE2)
               begin
                  if (act_rise)
                  begin
                     per_ff <= eff_p2;
                     state_ff <= ST_RUN;
                  end
               end
               else if (led_behavior_select == `LPB_BEH_BREATHE)
               begin
                  if (act_rise)
                  begin
                     per_ff <= eff_br;
                     state_ff <= ST_RUN;
                  end
               end
               else if (act_fall)
                  done_ff <= !linked && ramp_alert;
            end
            ST_RUN:
            begin
               if (!act)
               begin
                  if (led_behavior_select == `LPB_BEH_PULSE2)
                  begin
                     cnt_ff <= second_pulse_repeat_count;
                     pos_ff <= 7'h00;
                     state_ff <= ST_COUNT;
                  end
                  else
                  begin
                     state_ff <= ST_IDLE;
                     done_ff <= host_run_ff && ramp_alert;
                  end
               end
            end
            ST_COUNT:
            begin
               if (period_end)
               begin
                  if (cnt_ff == 3'h0)
                  begin
                     state_ff <= ST_IDLE;
                     done_ff <= host_run_ff && ramp_alert;
                  end
                  else
                     cnt_ff <= cnt_ff - 3'h1;
               end
            end
            default:
               state_ff <= ST_IDLE;
         endcase
         if (state_ff == ST_IDLE)
            led_out_ff <= (led_behavior_select == `LPB_BEH_DIRECT) && act;
         else
            led_out_ff <= ({1'b0, pwm_cnt_ff} < level);
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign led_out = led_out_ff;
   assign alert_n = alert_n_ff;
endmodule

// >>> verif/lpb_led_partner.sv
`timescale 1ns/1ns
// far side: touch pad plus a meter of lit cycles on the led
module lpb_led_partner
(
   input wire aclk,
   input wire press,
   input wire led_out,
   output logic touch_in = 1'b0,
   output int led_hi = 0
);
   always @(posedge aclk)
   begin
      touch_in <= press;
      if (led_out === 1'b1)
         led_hi <= led_hi + 1;
   end
endmodule

// >>> verif/lpb_led_timing_properties.sv
`timescale 1ns/1ns
`include "lpb_led_timing_defs.vh"
module lpb_led_timing_properties
#(
   parameter ADDR_W = 12,
   parameter TICK_CYCLES = 4
)
(
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire alert_n
);
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a[1:0] == 2'h0 && a[ADDR_W-1:2] inside {`LPB_IDX_P1_PERIOD, `LPB_IDX_P2_PERIOD,
         `LPB_IDX_BR_PERIOD, `LPB_IDX_CONFIG, `LPB_IDX_CONTROL, `LPB_IDX_STATUS};
   endfunction
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("no read data");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready)
      else $error("read not closed");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read upper bits set");
   rd_decode_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rresp == (mapped($past(s_axi_araddr)) ? `LPB_RESP_OKAY : `LPB_RESP_SLVERR)) else $error("bad rresp");
   alert_clear_a: assert property ($rose(alert_n) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("alert released without a write");
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `LPB_RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($fell(alert_n));
endmodule
bind lpb_led_timing lpb_led_timing_properties #(.ADDR_W(ADDR_W), .TICK_CYCLES(TICK_CYCLES)) lpb_props_inst (.aclk,
   .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .alert_n);

// >>> verif/lpb_led_timing_test.sv
`timescale 1ns/1ns
module lpb_led_timing_test;
   localparam tck = 4;
   localparam [11:0] a_p1 = 12'h210, a_p2 = 12'h214, a_br = 12'h218;
   localparam [11:0] a_cfg = 12'h220, a_ctl = 12'h228, a_st = 12'h22C;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, press;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, touch_in, led_out, alert_n;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int led_hi, n_fail, checks;
   lpb_led_timing #(.ADDR_W(12), .TICK_CYCLES(tck)) lpb_led_timing_inst (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .touch_in, .led_out, .alert_n);
   lpb_led_partner lpb_led_partner_inst (.aclk, .press, .led_out, .touch_in, .led_hi);
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %0h got %0h", what, exp, got);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         aw_ok = aw_ok || s_axi_awready;
         w_ok = w_ok || s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      chk("rresp", er, s_axi_rresp);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // tick divider may run free, so a start lands anywhere within one tick
   function automatic logic near(input int a, input int b);
      return a > b - tck && a < b + tck;
   endfunction
   task t_regs;
      logic [31:0] d;
      logic [11:0] ra [4] = '{a_p1, a_p2, a_br, a_cfg};
      logic [7:0] rv [4] = '{8'h20, 8'h14, 8'h5D, 8'h04};
      for (int i = 0; i < 4; i++)
      begin
         rd(ra[i], 2'h0, d);
         chk("reset value", {24'h0, rv[i]}, d);
      end
      rd(12'h200, 2'h2, d);
      chk("unmapped data", 32'h0, d);
      wr(12'h204, 8'hFF, 2'h2);
      wr(a_br, 8'hFF, 2'h0);
      rd(a_br, 2'h0, d);
      chk("breathe field", 32'h7F, d);
      s_axi_wstrb <= 4'h0;
      wr(a_br, 8'h11, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(a_br, 2'h0, d);
      chk("masked write", 32'h7F, d);
   endtask
   task t_breathe;
      logic [31:0] d;
      int h;
      wr(a_br, 8'h02, 2'h0);
      wr(a_ctl, 8'h04, 2'h0);
      h = led_hi;
      repeat (5) @(posedge aclk);
      chk("direct on", h + 5, led_hi);
      wr(a_ctl, 8'h00, 2'h0);
      h = led_hi;
      wr(a_ctl, 8'h07, 2'h0);
      repeat (40) @(posedge aclk);
      chk("breathe lit", 1, led_hi > h);
      wr(a_ctl, 8'h03, 2'h0);
      // last lit sample may still land on this edge
      @(posedge aclk);
      h = led_hi;
      repeat (30) @(posedge aclk);
      chk("breathe off", h, led_hi);
      wr(a_cfg, 8'h10, 2'h0);
      wr(a_p2, 8'h02, 2'h0);
      wr(a_ctl, 8'h06, 2'h0);
      repeat (20) @(posedge aclk);
      wr(a_ctl, 8'h02, 2'h0);
      rd(a_st, 2'h0, d);
      chk("pulse2 tail", 2, d[2:1]);
      repeat (30) @(posedge aclk);
      rd(a_st, 2'h0, d);
      chk("pulse2 end", 0, d[2:1]);
   endtask
   task run_len(input logic [7:0] per, input logic [7:0] cfg, output int n);
      wr(a_cfg, cfg, 2'h0);
      wr(a_p1, per, 2'h0);
      wr(a_ctl, 8'h05, 2'h0);
      n = 0;
      while (alert_n === 1'b1)
      begin
         @(posedge aclk);
         n++;
      end
      wr(a_ctl, 8'h01, 2'h0);
      wr(a_st, 8'h01, 2'h0);
      chk("alert cleared", 1, alert_n);
   endtask
   task t_pulse1;
      int n0, n1, n3, n5, nm, h;
      run_len(8'h00, 8'h41, n0);
      run_len(8'h01, 8'h41, n1);
      chk("zero period", 1, near(n0, n1));
      h = led_hi;
      run_len(8'h03, 8'h41, n3);
      chk("pulse lit", 1, led_hi > h);
      chk("period steps", 1, near(n3, n1 + 4 * tck));
      run_len(8'h01, 8'h44, n5);
      chk("pulse count", 1, near(n5, n1 + 3 * tck));
      run_len(8'h7F, 8'h40, nm);
      chk("max period", 1, near(nm, n1 + 125 * tck));
      // short run so it ends well inside the wait below
      wr(a_p1, 8'h01, 2'h0);
      wr(a_cfg, 8'h00, 2'h0);
      wr(a_ctl, 8'h05, 2'h0);
      repeat (40) @(posedge aclk);
      chk("alert off", 1, alert_n);
      wr(a_ctl, 8'h01, 2'h0);
   endtask
   task t_touch;
      logic [31:0] d;
      wr(a_cfg, 8'h40, 2'h0);
      wr(a_p1, 8'h90, 2'h0);
      wr(a_ctl, 8'h09, 2'h0);
      press <= 1'b1;
      repeat (30) @(posedge aclk);
      rd(a_st, 2'h0, d);
      chk("held touch", 0, d[2:1]);
      press <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(a_st, 2'h0, d);
      chk("release start", 2, d[2:1]);
      repeat (90) @(posedge aclk);
      chk("touch no alert", 1, alert_n);
   endtask
   task close_out;
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // whole run needs about 1100 cycles
   initial
   begin
      #200000;
      n_fail++;
      close_out;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, press} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_breathe;
      t_pulse1;
      t_touch;
      close_out;
   end
endmodule
